// File: logic/gpt_unit.sv
// Purpose: Five-timer general purpose timer unit, slow and fast modules.
// Assumes: i_ref_clk is the CPU clock; pins are asynchronous to it.
// Notes:   All state is one struct; one comb block, one register block.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`default_nettype none

module gpt_unit (
	input  wire logic                          i_ref_clk,
	input  wire logic                          i_sys_rst,
	input  wire logic [gpt_unit_pkg::AW-1:0]   i_addr,
	input  wire logic [gpt_unit_pkg::DW-1:0]   i_wdata,
	input  wire logic                          i_wr,
	input  wire logic                          i_rd,
	output logic      [gpt_unit_pkg::DW-1:0]   o_rdata,
	input  wire logic [gpt_unit_pkg::NT-1:0]   i_timer_gate_clock_input,
	input  wire logic [gpt_unit_pkg::NT-1:0]   i_timer_direction_input,
	input  wire logic                          i_capture_trigger_input,
	output logic      [1:0]                    o_toggle_latch_output_pin,
	output logic                               o_fast_toggle_output_pin,
	output logic                               o_compare_unit_clk,
	output logic      [gpt_unit_pkg::NI-1:0]   o_int_req
);

	// ****************************************************************
	// State
	// ****************************************************************
	gpt_unit_pkg::unit_state_s r_reg;
	gpt_unit_pkg::unit_state_s r_next;

	// Mask of low prescaler bits that must be all ones for a tick
	function automatic logic [7:0] pmask(input logic [2:0] e);
		logic [7:0] one;
		one = 8'h01;
		pmask = (one << e) - 8'h01;
	endfunction

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Timers are updated first, then reloads and captures, then software
	// writes, so a write wins over the hardware for that cycle, except on the request flags.
	always_comb begin
		logic                          slow_base;
		logic                          fast_base;
		logic                          ptick;
		logic                          en;
		logic                          dn;
		logic                          pin_ev;
		logic                          tog_ev;
		logic                          src_tog;
		logic                          core_ld;
		logic                          cap_ev;
		logic [gpt_unit_pkg::DW-1:0]   ctl;
		logic [gpt_unit_pkg::DW-1:0]   core_val;
		logic [7:0]                    pre;
		logic [7:0]                    pm;
		logic [2:0]                    ps;
		logic [1:0]                    es;
		logic [1:0]                    ces;
		logic [2:0]                    trise;
		logic [2:0]                    tfall;
		logic                          tr;
		logic                          tf;
		logic [gpt_unit_pkg::PN-1:0]   rise;
		logic [gpt_unit_pkg::PN-1:0]   fall;
		logic [gpt_unit_pkg::NT-1:0]   ev;
		logic [gpt_unit_pkg::NI-1:0]   set_req;
		gpt_unit_pkg::tmode_e          mode;
		r_next = r_reg;
		slow_base = 1'b0;
		fast_base = 1'b0;
		ptick = 1'b0;
		en = 1'b0;
		dn = 1'b0;
		pin_ev = 1'b0;
		tog_ev = 1'b0;
		src_tog = 1'b0;
		core_ld = 1'b0;
		cap_ev = 1'b0;
		ctl = '0;
		core_val = '0;
		pre = '0;
		pm = '0;
		ps = '0;
		es = '0;
		ces = '0;
		tr = 1'b0;
		tf = 1'b0;
		trise = '0;
		tfall = '0;
		rise = '0;
		fall = '0;
		ev = '0;
		set_req = '0;
		mode = gpt_unit_pkg::M_TIMER;

		// Three-stage synchroniser; the filtered level only moves once
		// stages two and three agree, so each pin change counts once
		r_next.s1 = {i_capture_trigger_input, i_timer_direction_input,
			i_timer_gate_clock_input};
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		for (int b = 0; b < gpt_unit_pkg::PN; b++) begin
			if (r_reg.s2[b] == r_reg.s3[b]) begin
				r_next.filt[b] = r_reg.s3[b];
			end
		end
		r_next.filt_d = r_reg.filt;
		rise = r_reg.filt & ~r_reg.filt_d;
		fall = ~r_reg.filt & r_reg.filt_d;
		trise = r_reg.tog & ~r_reg.tog_d;
		tfall = ~r_reg.tog & r_reg.tog_d;

		// Base dividers give the finest count period of each module
		slow_base = (r_reg.slow_div == gpt_unit_pkg::SLOW_LAST);
		fast_base = (r_reg.fast_div == gpt_unit_pkg::FAST_LAST);
		r_next.slow_div = slow_base ? 6'h00 : r_reg.slow_div + 6'h01;
		r_next.fast_div = fast_base ? 6'h00 : r_reg.fast_div + 6'h01;
		r_next.slow_pre = r_reg.slow_pre + {7'h00, slow_base};
		r_next.fast_pre = r_reg.fast_pre + {7'h00, fast_base};

		// Per-timer counting
		for (int t = 0; t < gpt_unit_pkg::NT; t++) begin
			ctl = r_reg.ctrl[t];
			mode = gpt_unit_pkg::tmode_e'(ctl[gpt_unit_pkg::F_MODE +: 3]);
			ps = ctl[gpt_unit_pkg::F_PS +: 3];
			es = ctl[gpt_unit_pkg::F_EDGE +: 2];
			pm = pmask(ps);
			pre = (t < gpt_unit_pkg::T_FA) ? r_reg.slow_pre : r_reg.fast_pre;
			ptick = ((t < gpt_unit_pkg::T_FA) ? slow_base : fast_base)
				&& ((pre & pm) == pm);
			pin_ev = (rise[t] & es[0]) | (fall[t] & es[1]);
			// Fast aux follows the fast core latch, slow timers the slow core latch
			tr = (t == gpt_unit_pkg::T_FA) ? trise[2] : trise[0];
			tf = (t == gpt_unit_pkg::T_FA) ? tfall[2] : tfall[0];
			tog_ev = (tr & es[0]) | (tf & es[1]);
			// A latch cannot clock its own timer, so cores ignore the source bit
			src_tog = ctl[gpt_unit_pkg::F_SRC] && (t != gpt_unit_pkg::T_SLC)
				&& (t != gpt_unit_pkg::T_FC);
			case (mode)
				gpt_unit_pkg::M_TIMER: begin
					en = ptick;
				end
				gpt_unit_pkg::M_COUNTER: begin
					en = src_tog ? tog_ev : pin_ev;
				end
				gpt_unit_pkg::M_GATE_LO: begin
					en = ptick & ~r_reg.filt[t];
				end
				gpt_unit_pkg::M_GATE_HI: begin
					en = ptick & r_reg.filt[t];
				end
				default: begin
					en = 1'b0;
				end
			endcase
			en = en & ctl[gpt_unit_pkg::F_RUN];
			dn = ctl[gpt_unit_pkg::F_DOWN] ^ (ctl[gpt_unit_pkg::F_XDIR]
				& r_reg.filt[gpt_unit_pkg::P_DIR + t]);
			if (en) begin
				if (dn) begin
					ev[t] = (r_reg.cnt[t] == 16'h0000);
					r_next.cnt[t] = r_reg.cnt[t] - 16'h0001;
				end else begin
					ev[t] = (r_reg.cnt[t] == 16'hFFFF);
					r_next.cnt[t] = r_reg.cnt[t] + 16'h0001;
				end
			end
			// Fast core may restart from the capture register on each wrap
			if ((t == gpt_unit_pkg::T_FC) && ev[t] && ctl[gpt_unit_pkg::F_RLD]) begin
				r_next.cnt[t] = r_reg.fast_capture_reload_reg;
			end
			// Slow aux timers as capture or reload registers of the core
			if ((t == gpt_unit_pkg::T_SLA) || (t == gpt_unit_pkg::T_SLB)) begin
				if ((mode == gpt_unit_pkg::M_CAPTURE) && pin_ev) begin
					r_next.cnt[t] = r_reg.cnt[gpt_unit_pkg::T_SLC];
					set_req[t] = 1'b1;
				end
				// Trigger from own pin or chosen core latch edge; two aux
				// timers on opposite edges alternate and give a free PWM
				if ((mode == gpt_unit_pkg::M_RELOAD)
					&& (ctl[gpt_unit_pkg::F_SRC] ? tog_ev : pin_ev)) begin
					core_ld = 1'b1;
					core_val = r_reg.cnt[t];
					set_req[t] = 1'b1;
				end
			end
		end
		set_req[gpt_unit_pkg::NT-1:0] = set_req[gpt_unit_pkg::NT-1:0] | ev;

		// Reload overrides the core's own count step in the same cycle
		if (core_ld) begin
			r_next.cnt[gpt_unit_pkg::T_SLC] = core_val;
		end

		// Capture of the fast aux timer, optionally clearing it afterwards
		ces = r_reg.ctrl[gpt_unit_pkg::T_FA][gpt_unit_pkg::F_CEDG +: 2];
		cap_ev = (rise[gpt_unit_pkg::P_CAP] & ces[0])
			| (fall[gpt_unit_pkg::P_CAP] & ces[1]);
		if (cap_ev) begin
			r_next.fast_capture_reload_reg = r_reg.cnt[gpt_unit_pkg::T_FA];
			set_req[gpt_unit_pkg::I_CR] = 1'b1;
			if (r_reg.ctrl[gpt_unit_pkg::T_FA][gpt_unit_pkg::F_CLR]) begin
				r_next.cnt[gpt_unit_pkg::T_FA] = 16'h0000;
			end
		end

		// Toggle latches flip on each wrap of their timer
		r_next.tog_d = r_reg.tog;
		r_next.tog[0] = r_reg.tog[0] ^ ev[gpt_unit_pkg::T_SLC];
		r_next.tog[1] = r_reg.tog[1] ^ ev[gpt_unit_pkg::T_SLB];
		r_next.tog[2] = r_reg.tog[2] ^ ev[gpt_unit_pkg::T_FC];

		// Software writes; unmapped addresses are ignored
		if (i_wr) begin
			if (i_addr < gpt_unit_pkg::A_FAST_CAPTURE_RELOAD_REG) begin
				r_next.cnt[i_addr - gpt_unit_pkg::A_CNT0] = i_wdata;
			end else if (i_addr == gpt_unit_pkg::A_FAST_CAPTURE_RELOAD_REG) begin
				r_next.fast_capture_reload_reg = i_wdata;
			end else if (i_addr < gpt_unit_pkg::A_INT0) begin
				r_next.ctrl[i_addr - gpt_unit_pkg::A_CTL0] = i_wdata;
			end else if (i_addr < gpt_unit_pkg::A_INT0 + 5'(gpt_unit_pkg::NI)) begin
				r_next.intctl[i_addr - gpt_unit_pkg::A_INT0] = i_wdata[7:0];
			end
		end

		// Request flags: a hardware set wins over a clear written alongside
		for (int k = 0; k < gpt_unit_pkg::NI; k++) begin
			if (set_req[k]) begin
				r_next.intctl[k][gpt_unit_pkg::F_IREQ] = 1'b1;
			end
			r_next.int_out[k] = r_next.intctl[k][gpt_unit_pkg::F_IREQ]
				& r_next.intctl[k][gpt_unit_pkg::F_IEN];
		end

		// Registered pin outputs, each gated by its timer's output enable
		r_next.tog_pin[0] = r_next.tog[0]
			& r_reg.ctrl[gpt_unit_pkg::T_SLC][gpt_unit_pkg::F_OE];
		r_next.tog_pin[1] = r_next.tog[1]
			& r_reg.ctrl[gpt_unit_pkg::T_SLB][gpt_unit_pkg::F_OE];
		r_next.fast_pin = r_next.tog[2]
			& r_reg.ctrl[gpt_unit_pkg::T_FC][gpt_unit_pkg::F_OE];
		r_next.cmp_clk = ev[gpt_unit_pkg::T_FC];

		// Read data show the values before this cycle's update
		if (i_rd) begin
			if (i_addr < gpt_unit_pkg::A_FAST_CAPTURE_RELOAD_REG) begin
				r_next.rdata = r_reg.cnt[i_addr - gpt_unit_pkg::A_CNT0];
			end else if (i_addr == gpt_unit_pkg::A_FAST_CAPTURE_RELOAD_REG) begin
				r_next.rdata = r_reg.fast_capture_reload_reg;
			end else if (i_addr < gpt_unit_pkg::A_INT0) begin
				r_next.rdata = r_reg.ctrl[i_addr - gpt_unit_pkg::A_CTL0];
			end else if (i_addr < gpt_unit_pkg::A_INT0 + 5'(gpt_unit_pkg::NI)) begin
				r_next.rdata = {8'h00, r_reg.intctl[i_addr - gpt_unit_pkg::A_INT0]};
			end else begin
				r_next.rdata = 16'h0000;                             // Unmapped
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Every field resets to zero: timers stopped, latches low
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			r_reg <= gpt_unit_pkg::STATE_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs come straight from the state register
	assign o_rdata = r_reg.rdata;
	assign o_toggle_latch_output_pin = r_reg.tog_pin;
	assign o_fast_toggle_output_pin = r_reg.fast_pin;
	assign o_compare_unit_clk = r_reg.cmp_clk;
	assign o_int_req = r_reg.int_out;

endmodule

`default_nettype wire

// File: logic/gpt_unit_pkg.sv
// Purpose: Constants and state layout for the general purpose timer unit.
// Assumes: One 100 MHz clock; registers reached over a plain strobe port.
// Notes:   Register index = port address; data is 16 bits wide.
`default_nettype none

package gpt_unit_pkg;

	// ****************************************************************
	// Sizes and indices
	// ****************************************************************
	localparam int NT = 5;              // Timers
	localparam int NI = 6;              // Interrupt sources
	localparam int PN = 11;             // Synchronised pins
	localparam int DW = 16;
	localparam int AW = 5;
	localparam int T_SLA = 0;           // slow_aux_timer_a
	localparam int T_SLC = 1;           // slow_core_timer
	localparam int T_SLB = 2;           // slow_aux_timer_b
	localparam int T_FA  = 3;           // fast_aux_timer
	localparam int T_FC  = 4;           // fast_core_timer
	localparam int I_CR  = 5;           // Capture register source
	localparam int P_DIR = 5;           // First direction pin bit
	localparam int P_CAP = 10;          // Capture trigger pin bit

	// ****************************************************************
	// Register map (index on the address port)
	// ****************************************************************
	localparam logic [AW-1:0] A_CNT0   = 5'h00;  // Timer counts 0..4
	localparam logic [AW-1:0] A_FAST_CAPTURE_RELOAD_REG = 5'h05;
	localparam logic [AW-1:0] A_CTL0   = 5'h06;  // Timer controls 6..10
	localparam logic [AW-1:0] A_INT0   = 5'h0B;  // Interrupt controls 11..16

	// ****************************************************************
	// Timer control fields
	// ****************************************************************
	localparam int F_MODE = 0;          // 3 bits
	localparam int F_PS   = 3;          // 3 bits, prescale exponent
	localparam int F_EDGE = 3;          // 2 bits, counter/trigger edges
	localparam int F_SRC  = 5;          // 1 = toggle latch source
	localparam int F_RUN  = 6;
	localparam int F_DOWN = 7;
	localparam int F_XDIR = 8;
	localparam int F_OE   = 9;
	localparam int F_CLR  = 10;         // Fast aux: clear after capture
	localparam int F_CEDG = 11;         // Fast aux: 2 bits capture edge
	localparam int F_RLD  = 13;         // Fast core: reload on wrap
	localparam int F_PRIO = 0;          // Interrupt: 4 bits priority
	localparam int F_IEN  = 6;
	localparam int F_IREQ = 7;

	typedef enum logic [2:0] {
		M_TIMER, M_COUNTER, M_GATE_LO, M_GATE_HI, M_RELOAD, M_CAPTURE
	} tmode_e;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ      = 100;
	localparam int SLOW_MIN_NS  = 400;
	localparam int FAST_MIN_NS  = 200;
	localparam int SLOW_BASE_CY = SLOW_MIN_NS * CLK_MHZ / 1000;
	localparam int FAST_BASE_CY = FAST_MIN_NS * CLK_MHZ / 1000;
	localparam logic [5:0] SLOW_LAST = 6'(SLOW_BASE_CY - 1);
	localparam logic [5:0] FAST_LAST = 6'(FAST_BASE_CY - 1);

	// ****************************************************************
	// Whole state of the unit
	// ****************************************************************
	typedef struct packed {
		logic [NT-1:0][DW-1:0] cnt;
		logic [DW-1:0]         fast_capture_reload_reg;
		logic [NT-1:0][DW-1:0] ctrl;
		logic [NI-1:0][7:0]    intctl;
		logic [PN-1:0]         s1;
		logic [PN-1:0]         s2;
		logic [PN-1:0]         s3;
		logic [PN-1:0]         filt;
		logic [PN-1:0]         filt_d;
		logic [5:0]            slow_div;
		logic [5:0]            fast_div;
		logic [7:0]            slow_pre;
		logic [7:0]            fast_pre;
		logic [2:0]            tog;
		logic [2:0]            tog_d;
		logic [DW-1:0]         rdata;
		logic [1:0]            tog_pin;
		logic                  fast_pin;
		logic                  cmp_clk;
		logic [NI-1:0]         int_out;
	} unit_state_s;

	localparam unit_state_s STATE_RST = '0;

endpackage

`default_nettype wire

// File: logic/_unused_guard.sv
`default_nettype none
`default_nettype wire

// File: tb/gpt_unit_properties.sv
// Purpose: Concurrent checks on the ports of the timer unit.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Sees only the top ports; bound after the module.
`default_nettype none

module gpt_unit_properties (
	input wire logic                        i_ref_clk,
	input wire logic                        i_sys_rst,
	input wire logic [gpt_unit_pkg::AW-1:0] i_addr,
	input wire logic [gpt_unit_pkg::DW-1:0] i_wdata,
	input wire logic                        i_wr,
	input wire logic                        i_rd,
	input wire logic [gpt_unit_pkg::DW-1:0] o_rdata,
	input wire logic [gpt_unit_pkg::NT-1:0] i_timer_gate_clock_input,
	input wire logic [gpt_unit_pkg::NT-1:0] i_timer_direction_input,
	input wire logic                        i_capture_trigger_input,
	input wire logic [1:0]                  o_toggle_latch_output_pin,
	input wire logic                        o_fast_toggle_output_pin,
	input wire logic                        o_compare_unit_clk,
	input wire logic [gpt_unit_pkg::NI-1:0] o_int_req
);
	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	logic       cap_prev_reg;
	logic [3:0] cap_age_reg;

	// Cycles since the capture pin last moved; saturates so it never wraps
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cap_prev_reg <= 1'b0;
			cap_age_reg <= 4'hF;
		end else begin
			cap_prev_reg <= i_capture_trigger_input;
			if (i_capture_trigger_input != cap_prev_reg) cap_age_reg <= 4'h0;
			else if (cap_age_reg != 4'hF) cap_age_reg <= cap_age_reg + 4'h1;
		end
	end

	property p_rdata_hold; !$past(i_rd) |-> $stable(o_rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_unmapped; i_rd && i_addr > 5'h10 |=> o_rdata == 16'h0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_cmp_single; o_compare_unit_clk |=> !o_compare_unit_clk; endproperty
	a_cmp_single: assert property (p_cmp_single) else $error("compare clock too long");
	// An enable write moves the pin two sampled edges later, a wrap at once
	property p_fast_pin;
		$changed(o_fast_toggle_output_pin) && !$past(i_wr, 2) |-> o_compare_unit_clk;
	endproperty
	a_fast_pin: assert property (p_fast_pin) else $error("fast latch moved without wrap");
	property p_int_hold; |($past(o_int_req) & ~o_int_req) |-> $past(i_wr); endproperty
	a_int_hold: assert property (p_int_hold) else $error("request dropped by itself");
	property p_fast_int;
		$rose(o_int_req[gpt_unit_pkg::T_FC]) |-> o_compare_unit_clk
			|| $past(o_compare_unit_clk) || $past(i_wr) || $past(i_wr, 2);
	endproperty
	a_fast_int: assert property (p_fast_int) else $error("fast core request without wrap");
	property p_cap_int;
		$rose(o_int_req[gpt_unit_pkg::I_CR]) |-> cap_age_reg < 4'hC || $past(i_wr) || $past(i_wr, 2);
	endproperty
	a_cap_int: assert property (p_cap_int) else $error("capture request without pin edge");
	property p_reset_quiet;
		$past(i_sys_rst) |-> o_int_req == '0 && o_rdata == '0 && !o_compare_unit_clk
			&& o_toggle_latch_output_pin == 2'h0 && !o_fast_toggle_output_pin;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
endmodule

bind gpt_unit gpt_unit_properties i_props (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_timer_gate_clock_input(i_timer_gate_clock_input),
	.i_timer_direction_input(i_timer_direction_input),
	.i_capture_trigger_input(i_capture_trigger_input),
	.o_toggle_latch_output_pin(o_toggle_latch_output_pin),
	.o_fast_toggle_output_pin(o_fast_toggle_output_pin),
	.o_compare_unit_clk(o_compare_unit_clk), .o_int_req(o_int_req));

`default_nettype wire

// File: tb/gpt_pin_model.sv
// Purpose: Far-side model driving gate, event, direction and capture pins.
// Assumes: Pins are plain levels with no pull; index 5 means capture pin.
// Notes:   Levels are held long enough to pass the input filter.
`default_nettype none

module gpt_pin_model (
	input  wire logic                        i_ref_clk,
	output logic      [gpt_unit_pkg::NT-1:0] o_gate,
	output logic      [gpt_unit_pkg::NT-1:0] o_dir,
	output logic                             o_cap
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	localparam int HOLD = 8; // Well past sync plus filter, so each edge counts once

	// Quiet pins from time zero
	initial begin
		o_gate = '0;
		o_dir = '0;
		o_cap = 1'b0;
	end

	// One pin per timer carries gate or event level
	task automatic set_gate(input int b, input logic v);
		@(posedge i_ref_clk);
		if (b == 5) o_cap <= v;
		else o_gate[b] <= v;
	endtask

	// Whole pulses only: high and low each held for the filter
	task automatic pulse(input int b, input int n);
		repeat (n) begin
			set_gate(b, 1'b1);
			repeat (HOLD) @(posedge i_ref_clk);
			set_gate(b, 1'b0);
			repeat (HOLD) @(posedge i_ref_clk);
		end
	endtask

	// Direction level, changed only between events
	task automatic set_dir(input int b, input logic v);
		@(posedge i_ref_clk);
		o_dir[b] <= v;
	endtask
endmodule

`default_nettype wire

// File: tb/general_purpose_timer_unit_tb_top.sv
// Purpose: Self-checking bench for the timer unit.
// Assumes: 100 MHz clock; strobe register port with one-cycle read data.
// Notes:   Expectations come from a queue model and fixed tables.
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end

module general_purpose_timer_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Bench
	// ****************************************************************
	logic                        i_ref_clk;
	logic                        i_sys_rst;
	logic [gpt_unit_pkg::AW-1:0] i_addr;
	logic [gpt_unit_pkg::DW-1:0] i_wdata;
	logic                        i_wr;
	logic                        i_rd;
	logic [gpt_unit_pkg::DW-1:0] o_rdata;
	logic [gpt_unit_pkg::NT-1:0] gate;
	logic [gpt_unit_pkg::NT-1:0] dir;
	logic                        cap;
	logic [1:0]                  tog_pin;
	logic                        fast_pin;
	logic                        cmp_clk;
	logic [gpt_unit_pkg::NI-1:0] int_req;
	int                          n_errors;
	int                          checks_done;
	int                          cyc;
	integer                      seed;
	logic [15:0]                 q[$];
	int                          tc_t[4]     = '{1, 1, 4, 4};
	logic [15:0]                 tc_ctl[4]   = '{16'h0240, 16'h02C0, 16'h0240, 16'h2240};
	logic [15:0]                 tc_start[4] = '{16'hFFFE, 16'h0001, 16'hFFFF, 16'hFFFE};
	logic [15:0]                 tc_after[4] = '{16'h0002, 16'hFFFD, 16'h0002, 16'h1002};
	logic                        tc_pin[4]   = '{1'b1, 1'b0, 1'b1, 1'b0};

	gpt_unit i_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_timer_gate_clock_input(gate), .i_timer_direction_input(dir),
		.i_capture_trigger_input(cap), .o_toggle_latch_output_pin(tog_pin),
		.o_fast_toggle_output_pin(fast_pin), .o_compare_unit_clk(cmp_clk), .o_int_req(int_req));
	gpt_pin_model i_pins (.i_ref_clk(i_ref_clk), .o_gate(gate), .o_dir(dir), .o_cap(cap));

	// Free-running clock and a hang guard far above the expected run length
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
	end

	// Bus cycles: one strobe cycle each, read data taken the cycle after
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask
	task automatic chk_rd(input logic [4:0] a, input logic [15:0] ex, input string nm);
		logic [15:0] got;
		rd(a, got);
		`CHK(nm, ex, got)
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		int          a;
		int          k;
		int          b;
		logic [15:0] d;
		logic [15:0] m;
		logic        seen;
		seed = 32'h3ae636bf;
		{i_addr, i_wdata, i_wr, i_rd, n_errors, checks_done, cyc} = '0;
		i_sys_rst = 1'b1;
		repeat (3) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		for (a = 0; a < 32; a++) chk_rd(5'(a), 16'h0000, "reset");
		$display("test reset done");
		// Random writes one every other cycle, queue holds what each place should return
		for (a = 0; a < 17; a++) begin
			if (a < 6 || a > 10) begin
				d = 16'($random(seed)) & ((a > 10) ? 16'h000F : 16'hFFFF);
				q.push_back(d);
				wr(5'(a), d);
			end
		end
		for (a = 0; a < 17; a++) begin
			if (a < 6 || a > 10) chk_rd(5'(a), q.pop_front(), "readback");
		end
		$display("test readback done");
		// Wrap table: up, down, fast, fast with reload; then tick spacing
		wr(5'h05, 16'h1000);
		for (k = 0; k < 4; k++) begin
			b = tc_t[k];
			m = (b == 4) ? 16'(gpt_unit_pkg::FAST_BASE_CY) : 16'(gpt_unit_pkg::SLOW_BASE_CY);
			wr(5'(11 + b), 16'h0040);
			wr(5'(b), tc_start[k]);
			wr(5'(6 + b), tc_ctl[k]);
			seen = 1'b0;
			for (a = 0; a < 300 && int_req[b] !== 1'b1; a++) begin
				@(posedge i_ref_clk);
				#1;
				seen |= cmp_clk;
			end
			`CHK("wrap_req", 1'b1, int_req[b])
			`CHK("cmp_pulse", b == 4, seen)
			`CHK("latch_pin", tc_pin[k], (b == 4) ? fast_pin : tog_pin[0])
			repeat (2 * m + m / 2) @(posedge i_ref_clk);
			chk_rd(5'(b), tc_after[k], "ticks");
			wr(5'(6 + b), tc_ctl[k] & 16'hFFBF);
			wr(5'(11 + b), 16'h0000);
		end
		$display("test wrap done");
		// Counter mode on rising edges, then external direction turns it down
		wr(5'h03, 16'h0000);
		wr(5'h09, 16'h0049);
		i_pins.pulse(3, 5);
		chk_rd(5'h03, 16'h0005, "events_up");
		wr(5'h09, 16'h0149);
		i_pins.set_dir(3, 1'b1);
		repeat (10) @(posedge i_ref_clk);
		i_pins.pulse(3, 3);
		chk_rd(5'h03, 16'h0002, "events_down");
		wr(5'h09, 16'h0000);
		i_pins.set_dir(3, 1'b0);
		$display("test counter done");
		// Gated on high level: nothing while low, ten base periods while high
		wr(5'h00, 16'h0000);
		wr(5'h06, 16'h0043);
		repeat (200) @(posedge i_ref_clk);
		chk_rd(5'h00, 16'h0000, "gate_shut");
		i_pins.set_gate(0, 1'b1);
		repeat (400) @(posedge i_ref_clk);
		i_pins.set_gate(0, 1'b0);
		repeat (20) @(posedge i_ref_clk);
		rd(5'h00, d);
		`CHK("gate_open", 1'b1, d >= 16'h0009 && d <= 16'h000B)
		// Gated on low level with the pin low: about five base periods
		wr(5'h00, 16'h0000);
		wr(5'h06, 16'h0042);
		repeat (200) @(posedge i_ref_clk);
		rd(5'h00, d);
		`CHK("gate_low", 1'b1, d >= 16'h0005 && d <= 16'h0006)
		wr(5'h06, 16'h0000);
		$display("test gated done");
		// Slow capture into aux b, then reload of core from aux a
		wr(5'h01, 16'h0ABC);
		wr(5'h08, 16'h004D);
		i_pins.pulse(2, 1);
		chk_rd(5'h02, 16'h0ABC, "slow_capture");
		wr(5'h00, 16'h5555);
		wr(5'h06, 16'h004C);
		i_pins.pulse(0, 1);
		chk_rd(5'h01, 16'h5555, "slow_reload");
		chk_rd(5'h00, 16'h5555, "aux_still");
		$display("test capture_reload done");
		// Core latch clocks aux a on both edges; aux b wraps and drives its pin
		wr(5'h00, 16'h0000);
		wr(5'h06, 16'h0079);
		wr(5'h01, 16'hFFFF);
		wr(5'h02, 16'hFFFF);
		wr(5'h0D, 16'h0040);
		wr(5'h07, 16'h0040);
		wr(5'h08, 16'h0240);
		for (a = 0; a < 100 && int_req[2] !== 1'b1; a++) begin
			@(posedge i_ref_clk);
			#1;
		end
		`CHK("auxb_req", 1'b1, int_req[2])
		`CHK("auxb_pin", 1'b1, tog_pin[1])
		chk_rd(5'h00, 16'h0001, "latch_clock");
		$display("test latch_clock done");
		// Fast capture with clear of the fast aux afterwards
		wr(5'h03, 16'h1234);
		wr(5'h09, 16'h0C00);
		wr(5'h10, 16'h0040);
		i_pins.pulse(5, 1);
		for (a = 0; a < 100 && int_req[5] !== 1'b1; a++) begin
			@(posedge i_ref_clk);
			#1;
		end
		`CHK("cap_req", 1'b1, int_req[5])
		chk_rd(5'h05, 16'h1234, "fast_capture_reload_reg");
		chk_rd(5'h03, 16'h0000, "aux_cleared");
		wr(5'h10, 16'h0000);
		$display("test fast_capture done");
		give_verdict();
	end
endmodule

`default_nettype wire
